// File: core/ledsfi_defs.svh
// Constants of the LED driver serial frame interface: field positions, codes and reset values.
// Assumes inclusion by the package and by the core; holds definitions only.
// Operation
// - Resistor open or short: flag, latch off, failsafe
// - Resistor flags clear on read, reset, enable
// - Warning sets flag, failsafe low while present
// - Warning mask keeps failsafe high, flag still set
// - Shutdown: channels off, flag, failsafe low
// - Shutdown ends with indication, settings kept
// - Link rate from 150kbps to 2Mbps
// - Sync byte measured for every transaction
// - Write frame, then status and CRC reply
// - Sixteen-bit values travel low byte first
// - Read frame, then status, data, CRC reply
// - Sync byte excluded from CRC
// - Upper nibble must match own identifier
// - Bit three selects broadcast, writes only
// - Low three bits give command and length
// - Start address 0x00 through 0x33
// - Status byte layout with failsafe level bit
// - CRC-8 poly 0x31, init 0xFF, xorout 0x00
// - Fault status register clears when read
`ifndef LEDSFI_DEFS_SVH
`define LEDSFI_DEFS_SVH
`define LEDSFI_P_RXD 0
`define LEDSFI_P_EN 1
`define LEDSFI_P_ID_LO 2
`define LEDSFI_P_ID_HI 5
`define LEDSFI_P_OPEN 6
`define LEDSFI_P_SHORT 7
`define LEDSFI_P_WARN 8
`define LEDSFI_P_SD 9
`define LEDSFI_NPINS 10
`define LEDSFI_CRC_POLY 8'h31
`define LEDSFI_CRC_INIT 8'hff
`define LEDSFI_ADDR_MAX 8'h33
`define LEDSFI_FLAG_ADDR 8'h06
`define LEDSFI_FB_WARN 13
`define LEDSFI_FB_SHORT 12
`define LEDSFI_FB_OPEN 11
`define LEDSFI_FB_SD 9
`define LEDSFI_SYNC_FALLS 3'h3
`define LEDSFI_SYNC_BITS_LOG2 3
`define LEDSFI_IDLE_BITS_LOG2 4
`define LEDSFI_CNT_MAX 12'hfff
`define LEDSFI_STAT_BASE 8'h80
`define LEDSFI_SB_SHORT 5
`define LEDSFI_SB_OPEN 4
`define LEDSFI_SB_FS 3
`endif

// File: core/ledsfi_pkg.sv
// Types of the LED driver serial frame interface.
// Assumes the constants header sits beside it.
`include "ledsfi_defs.svh"
package ledsfi_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_SYNC, S_WAITHI, S_BWAIT, S_RX, S_CHECK, S_WR, S_FETCH, S_TXL, S_TX
  } ledsfi_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [1:0] wbe;
  } ledsfi_req_s;

  typedef struct packed {
    logic ref_resistor_open_flag;
    logic ref_resistor_short_flag;
    logic overtemp_warning_flag;
    logic overtemp_shutdown_flag;
  } ledsfi_flags_s;

  typedef struct packed {
    logic [`LEDSFI_NPINS-1:0] sq1;
    logic [`LEDSFI_NPINS-1:0] sq2;
    logic rx_d;
    logic en_d;
    ledsfi_state_e st;
    logic [11:0] cnt;
    logic [2:0] falls;
    logic [8:0] bitp;
    logic [3:0] bitn;
    logic [9:0] shreg;
    logic [3:0] bidx;
    logic [7:0] dev_b;
    logic [7:0] reg_b;
    logic [7:0] crc;
    logic [7:0][7:0] dbuf;
    logic ph;
    logic reference_resistor_pin_lat;
    ledsfi_flags_s flags;
    logic txd;
    logic failsafe_n;
    logic ch_off;
    ledsfi_req_s req;
  } ledsfi_st_s;
endpackage

// File: core/ledsfi_core.sv
// Frame interpreter of the LED driver: baud recovery, frame decode, register requests, reply and fault flags.
// Assumes reg_rdata answers combinationally to reg_req.addr and that the analog
// comparators apply their own thresholds and hysteresis.
`timescale 1ns/1ps
`include "ledsfi_defs.svh"
module ledsfi_core (
  input wire logic clk, // 50 MHz clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic rxd, // Receive data from transceiver
  input wire logic en, // Enable pin, low resets faults
  input wire logic [3:0] dev_id, // Pin-configured identifier
  input wire logic ref_open_det, // Reference resistor open comparator
  input wire logic ref_short_det, // Reference resistor short comparator
  input wire logic temp_warn_det, // Thermal warning comparator
  input wire logic temp_sd_det, // Thermal shutdown comparator
  input wire logic overtemp_warning_failsafe_mask, // Warning does not pull failsafe
  input wire logic any_channel_shorted, // Some channel is shorted
  input wire logic any_channel_unloaded, // Some channel is open
  input wire logic [15:0] reg_rdata, // Register read data
  output logic txd, // Transmit data, idle high
  output logic failsafe_n, // Failsafe, low on fault
  output logic channels_off, // All output channels off
  output ledsfi_pkg::ledsfi_req_s reg_req, // Register request
  output ledsfi_pkg::ledsfi_flags_s fault_flags // Sticky fault flags
);

  ledsfi_pkg::ledsfi_st_s s_r;
  ledsfi_pkg::ledsfi_st_s s_nxt;
  logic rx;
  logic fall;
  logic en_s;
  logic [3:0] id_s;
  logic [9:0] rxw;
  logic [3:0] nb;
  logic [3:0] last;
  logic accept;
  logic [7:0] waddr;
  logic [15:0] rword;
  logic [7:0] tbyte;
  logic flag_rd;

  // CRC-8, most significant bit first, used for both directions.
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ `LEDSFI_CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

  // Byte count of a command: 1, 2, 4 or 8.
  function automatic logic [3:0] cmd_len(input logic [7:0] dev);
    return 4'h1 << dev[1:0];
  endfunction

  // Read commands carry a one in the top bit of the command field.
  function automatic logic is_read(input logic [7:0] dev);
    return dev[2];
  endfunction

  // Index of the CRC byte within a received frame.
  function automatic logic [3:0] frame_last(input logic [7:0] dev, input logic [3:0] n);
    return is_read(dev) ? 4'h2 : 4'h2 + n;
  endfunction

  // Index of the CRC byte within the reply.
  function automatic logic [3:0] reply_last(input logic [7:0] dev, input logic [3:0] n);
    return is_read(dev) ? n + 4'h1 : 4'h1;
  endfunction

  // Only addresses inside the map raise a request; beyond it reads return zero.
  function automatic logic addr_ok(input logic [7:0] a);
    return a <= `LEDSFI_ADDR_MAX;
  endfunction

  // Half a bit period puts the receive sample in the middle of each bit.
  function automatic logic [11:0] half_bit(input logic [8:0] bp);
    return {4'h0, bp[8:1]};
  endfunction

  // A broadcast frame is taken by every device, but only when it writes.
  function automatic logic accepted(input logic [7:0] dev, input logic [3:0] id);
    if (dev[3]) begin
      return !is_read(dev);
    end
    return dev[7:4] == id;
  endfunction

  // Fault register image; the reserved bits read as zero.
  function automatic logic [15:0] flag_word(input ledsfi_pkg::ledsfi_flags_s f);
    logic [15:0] w;
    w = 16'h0000;
    w[`LEDSFI_FB_OPEN] = f.ref_resistor_open_flag;
    w[`LEDSFI_FB_SHORT] = f.ref_resistor_short_flag;
    w[`LEDSFI_FB_WARN] = f.overtemp_warning_flag;
    w[`LEDSFI_FB_SD] = f.overtemp_shutdown_flag;
    return w;
  endfunction

  // Reply status byte; the channel summaries are taken as they stand when the byte is loaded.
  function automatic logic [7:0] status_byte(input logic shorted, input logic unloaded, input logic fs_n);
    logic [7:0] b;
    b = `LEDSFI_STAT_BASE;
    b[`LEDSFI_SB_SHORT] = shorted;
    b[`LEDSFI_SB_OPEN] = unloaded;
    b[`LEDSFI_SB_FS] = fs_n;
    return b;
  endfunction

  // Sticky fault flags. The read clear comes first so that a fault present in the same cycle survives it.
  function automatic ledsfi_pkg::ledsfi_flags_s next_flags(
    input ledsfi_pkg::ledsfi_flags_s cur,
    input logic rd_clr,
    input logic en_lvl,
    input logic [`LEDSFI_NPINS-1:0] pins
  );
    ledsfi_pkg::ledsfi_flags_s f;
    f = cur;
    if (rd_clr) begin
      f = '0;
    end
    if (!en_lvl) begin
      f = '0;
    end else begin
      if (pins[`LEDSFI_P_OPEN]) begin
        f.ref_resistor_open_flag = 1'b1;
      end
      if (pins[`LEDSFI_P_SHORT]) begin
        f.ref_resistor_short_flag = 1'b1;
      end
      if (pins[`LEDSFI_P_WARN]) begin
        f.overtemp_warning_flag = 1'b1;
      end
      if (pins[`LEDSFI_P_SD]) begin
        f.overtemp_shutdown_flag = 1'b1;
      end
    end
    return f;
  endfunction

  assign rx = s_r.sq2[`LEDSFI_P_RXD];
  assign fall = s_r.rx_d & ~rx;
  assign en_s = s_r.sq2[`LEDSFI_P_EN];
  assign id_s = s_r.sq2[`LEDSFI_P_ID_HI:`LEDSFI_P_ID_LO];
  assign nb = cmd_len(s_r.dev_b);

  always_comb begin
    s_nxt = s_r;
    rxw = {rx, s_r.shreg[9:1]};
    last = frame_last(s_r.dev_b, nb);
    accept = 1'b0;
    waddr = s_r.reg_b + {5'h00, s_r.bidx[3:1]};
    rword = reg_rdata;
    tbyte = `LEDSFI_STAT_BASE;
    flag_rd = 1'b0;
    s_nxt.sq1 = {temp_sd_det, temp_warn_det, ref_short_det, ref_open_det, dev_id, en, rxd};
    s_nxt.sq2 = s_r.sq1;
    s_nxt.rx_d = rx;
    s_nxt.en_d = en_s;
    s_nxt.req.wr = 1'b0;
    s_nxt.req.rd = 1'b0;
    unique case (s_r.st)
      ledsfi_pkg::S_IDLE: begin
        s_nxt.txd = 1'b1;
        if (fall) begin
          s_nxt.st = ledsfi_pkg::S_SYNC;
          s_nxt.cnt = 12'h000;
          s_nxt.falls = 3'h0;
        end
      end
      ledsfi_pkg::S_SYNC: begin
        // The sync pattern gives falling edges two bit times apart; eight bits span the first to the fifth.
        s_nxt.cnt = s_r.cnt + 12'h001;
        if (s_r.cnt == `LEDSFI_CNT_MAX) begin
          s_nxt.st = ledsfi_pkg::S_IDLE;
        end else if (fall) begin
          s_nxt.falls = s_r.falls + 3'h1;
          if (s_r.falls == `LEDSFI_SYNC_FALLS) begin
            s_nxt.bitp = s_r.cnt[11:`LEDSFI_SYNC_BITS_LOG2];
            s_nxt.st = ledsfi_pkg::S_WAITHI;
          end
        end
      end
      ledsfi_pkg::S_WAITHI: begin
        if (rx) begin
          s_nxt.st = ledsfi_pkg::S_BWAIT;
          s_nxt.cnt = 12'h000;
          s_nxt.bidx = 4'h0;
          s_nxt.crc = `LEDSFI_CRC_INIT;
        end
      end
      ledsfi_pkg::S_BWAIT: begin
        // Below a bitp of 255, a frame that stalls for sixteen bit times is dropped so a lost byte cannot hang the link.
        s_nxt.cnt = s_r.cnt + 12'h001;
        if (fall) begin
          s_nxt.st = ledsfi_pkg::S_RX;
          s_nxt.cnt = half_bit(s_r.bitp);
          s_nxt.bitn = 4'h0;
        end else if (s_r.cnt[11:`LEDSFI_IDLE_BITS_LOG2] > {3'h0, s_r.bitp}) begin
          s_nxt.st = ledsfi_pkg::S_IDLE;
        end
      end
      ledsfi_pkg::S_RX: begin
        s_nxt.cnt = s_r.cnt - 12'h001;
        if (s_r.cnt == 12'h000) begin
          s_nxt.shreg = rxw;
          s_nxt.bitn = s_r.bitn + 4'h1;
          s_nxt.cnt = {3'h0, s_r.bitp} - 12'h001;
          if (s_r.bitn == 4'h9) begin
            if (rxw[0] || !rxw[9]) begin
              s_nxt.st = ledsfi_pkg::S_IDLE;
            end else begin
              s_nxt.crc = crc8(s_r.crc, rxw[8:1]);
              s_nxt.bidx = s_r.bidx + 4'h1;
              s_nxt.cnt = 12'h000;
              s_nxt.st = (s_r.bidx == last) ? ledsfi_pkg::S_CHECK : ledsfi_pkg::S_BWAIT;
              if (s_r.bidx == 4'h0) begin
                s_nxt.dev_b = rxw[8:1];
              end else if (s_r.bidx == 4'h1) begin
                s_nxt.reg_b = rxw[8:1];
              end else if (s_r.bidx != last) begin
                s_nxt.dbuf[s_r.bidx[2:0] - 3'h2] = rxw[8:1];
              end
            end
          end
        end
      end
      ledsfi_pkg::S_CHECK: begin
        // Running the CRC over the check byte leaves zero on a good frame.
        accept = accepted(s_r.dev_b, id_s);
        s_nxt.bidx = 4'h0;
        s_nxt.ph = 1'b0;
        if (s_r.crc != 8'h00 || !accept) begin
          s_nxt.st = ledsfi_pkg::S_IDLE;
        end else begin
          s_nxt.st = s_r.dev_b[2] ? ledsfi_pkg::S_FETCH : ledsfi_pkg::S_WR;
        end
      end
      ledsfi_pkg::S_WR: begin
        // Writes are held until the CRC is good, so a bad frame changes nothing.
        s_nxt.req.wr = addr_ok(waddr);
        s_nxt.req.addr = waddr;
        s_nxt.req.wdata = {s_r.dbuf[s_r.bidx[2:0] + 3'h1], s_r.dbuf[s_r.bidx[2:0]]};
        s_nxt.req.wbe = (nb == 4'h1) ? 2'b01 : 2'b11;
        s_nxt.bidx = s_r.bidx + 4'h2;
        if (s_r.bidx + 4'h2 >= nb) begin
          s_nxt.bidx = 4'h0;
          s_nxt.crc = `LEDSFI_CRC_INIT;
          s_nxt.st = s_r.dev_b[3] ? ledsfi_pkg::S_IDLE : ledsfi_pkg::S_TXL;
        end
      end
      ledsfi_pkg::S_FETCH: begin
        s_nxt.ph = ~s_r.ph;
        if (!s_r.ph) begin
          s_nxt.req.rd = addr_ok(waddr);
          s_nxt.req.addr = waddr;
        end else begin
          if (s_r.req.addr == `LEDSFI_FLAG_ADDR) begin
            flag_rd = 1'b1;
            rword = flag_word(s_r.flags);
          end else if (!addr_ok(s_r.req.addr)) begin
            rword = 16'h0000;
          end
          s_nxt.dbuf[s_r.bidx[2:0]] = rword[7:0];
          s_nxt.dbuf[s_r.bidx[2:0] + 3'h1] = rword[15:8];
          s_nxt.bidx = s_r.bidx + 4'h2;
          if (s_r.bidx + 4'h2 >= nb) begin
            s_nxt.bidx = 4'h0;
            s_nxt.crc = `LEDSFI_CRC_INIT;
            s_nxt.st = ledsfi_pkg::S_TXL;
          end
        end
      end
      ledsfi_pkg::S_TXL: begin
        // Reply order: status, data for reads, then the CRC over both.
        tbyte = status_byte(any_channel_shorted, any_channel_unloaded, s_r.failsafe_n);
        if (s_r.bidx == reply_last(s_r.dev_b, nb)) begin
          tbyte = s_r.crc;
        end else if (s_r.bidx != 4'h0) begin
          tbyte = s_r.dbuf[s_r.bidx[2:0] - 3'h1];
        end
        s_nxt.crc = crc8(s_r.crc, tbyte);
        s_nxt.shreg = {1'b1, tbyte, 1'b0};
        s_nxt.txd = 1'b0;
        s_nxt.bitn = 4'h0;
        s_nxt.cnt = {3'h0, s_r.bitp} - 12'h001;
        s_nxt.st = ledsfi_pkg::S_TX;
      end
      ledsfi_pkg::S_TX: begin
        s_nxt.cnt = s_r.cnt - 12'h001;
        if (s_r.cnt == 12'h000) begin
          s_nxt.cnt = {3'h0, s_r.bitp} - 12'h001;
          if (s_r.bitn == 4'h9) begin
            s_nxt.bidx = s_r.bidx + 4'h1;
            if (s_r.bidx == reply_last(s_r.dev_b, nb)) begin
              s_nxt.st = ledsfi_pkg::S_IDLE;
            end else begin
              s_nxt.st = ledsfi_pkg::S_TXL;
            end
          end else begin
            s_nxt.shreg = {1'b1, s_r.shreg[9:1]};
            s_nxt.txd = s_r.shreg[1];
            s_nxt.bitn = s_r.bitn + 4'h1;
          end
        end
      end
      default: begin
        s_nxt.st = ledsfi_pkg::S_IDLE;
      end
    endcase

    s_nxt.flags = next_flags(s_r.flags, flag_rd, en_s, s_r.sq2);
    // The resistor latch only lets go on a rising enable; reading the flags does not release it.
    if (en_s && !s_r.en_d) begin
      s_nxt.reference_resistor_pin_lat = 1'b0;
    end
    if (s_r.sq2[`LEDSFI_P_OPEN] || s_r.sq2[`LEDSFI_P_SHORT]) begin
      s_nxt.reference_resistor_pin_lat = 1'b1;
    end
    // Shutdown follows the comparator, whose hysteresis sets the recovery point; settings are untouched.
    s_nxt.ch_off = s_nxt.reference_resistor_pin_lat || s_r.sq2[`LEDSFI_P_SD];
    s_nxt.failsafe_n = !(s_nxt.reference_resistor_pin_lat || s_r.sq2[`LEDSFI_P_SD] ||
                         (s_r.sq2[`LEDSFI_P_WARN] && !overtemp_warning_failsafe_mask));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.st <= ledsfi_pkg::S_IDLE;
      s_r.txd <= 1'b1;
      s_r.failsafe_n <= 1'b1;
      s_r.crc <= `LEDSFI_CRC_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign txd = s_r.txd;
  assign failsafe_n = s_r.failsafe_n;
  assign channels_off = s_r.ch_off;
  assign reg_req = s_r.req;
  assign fault_flags = s_r.flags;

endmodule // ledsfi_core

// File: tb/ledsfi_properties.sv
// Checker for the frame interface: fault outputs and register request timing.
// Assumes it is bound onto ledsfi_core; every comparator passes two sync stages and an output register.
`timescale 1ns/1ps
module ledsfi_properties (
  input wire logic clk, // Clock
  input wire logic srst, // Synchronous reset
  input wire logic en, // Enable pin
  input wire logic ref_open_det, // Open comparator
  input wire logic ref_short_det, // Short comparator
  input wire logic temp_warn_det, // Warning comparator
  input wire logic temp_sd_det, // Shutdown comparator
  input wire logic overtemp_warning_failsafe_mask, // Warning mask
  input wire logic failsafe_n, // Failsafe level
  input wire logic channels_off, // Channels off
  input wire ledsfi_pkg::ledsfi_req_s reg_req, // Register request
  input wire ledsfi_pkg::ledsfi_flags_s fault_flags // Sticky flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_REF_LATCH: assert property (ref_open_det |-> ##3 (!failsafe_n && channels_off))
    else $error("resistor fault did not latch outputs off");
  AST_REF_FLAG: assert property (ref_short_det |-> ##3 fault_flags.ref_resistor_short_flag)
    else $error("short flag not set");
  AST_EN_CLEAR: assert property (!en [*4] |-> fault_flags == 4'h0)
    else $error("flags survive enable low");
  AST_WARN_FS: assert property ((temp_warn_det && !overtemp_warning_failsafe_mask) [*4] |-> !failsafe_n)
    else $error("warning did not pull failsafe");
  AST_WARN_FLAG: assert property (temp_warn_det |-> ##3 fault_flags.overtemp_warning_flag)
    else $error("warning flag not set");
  AST_SD_OFF: assert property (temp_sd_det |-> ##3 (channels_off && !failsafe_n && fault_flags.overtemp_shutdown_flag))
    else $error("shutdown did not turn channels off");
  AST_ADDR_RANGE: assert property ((reg_req.wr || reg_req.rd) |-> reg_req.addr <= 8'h33)
    else $error("request beyond last register");
  AST_RD_GAP: assert property (reg_req.rd |=> !(reg_req.rd || reg_req.wr))
    else $error("read requests too close");
  AST_WR_STEP: assert property (reg_req.wr ##1 reg_req.wr |-> reg_req.addr == $past(reg_req.addr) + 8'h01)
    else $error("write address did not step");
  AST_RD_STEP: assert property (reg_req.rd ##2 reg_req.rd |-> reg_req.addr == $past(reg_req.addr, 2) + 8'h01)
    else $error("read address did not step");
endmodule // ledsfi_properties

// File: tb/ledsfi_host.sv
// Host model: sends frames opened by the sync byte on rxd and collects the reply on txd.
// Assumes the shared clock; the bus idles recessive, which the core reads as high.
`timescale 1ns/1ps
module ledsfi_host (
  input wire logic clk, // Shared clock
  input wire logic txd, // Reply from the device
  output logic rxd // Frame to the device
);
  initial rxd = 1'b1;
  function automatic logic [7:0] crc8(input logic [7:0] b[$]);
    logic [7:0] c;
    c = 8'hff;
    foreach (b[i]) begin
      c ^= b[i];
      for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  // The stop bit of the last byte is left short so the reply start bit is never missed.
  task automatic put(input logic [7:0] b, input int bp, input int nb);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd = f[i];
      if (i < nb) repeat (bp) @(negedge clk);
    end
  endtask
  task automatic frame(input logic [7:0] q[$], input int bp, input int nrx, input logic bad,
                       output logic [7:0] r[$]);
    logic [7:0] b;
    int w;
    r = {};
    put(8'h55, bp, 10);
    foreach (q[i]) put(q[i], bp, 10);
    put(crc8(q) ^ {7'h0, bad}, bp, 9);
    for (int n = 0; n < nrx; n++) begin
      w = 0;
      while (txd !== 1'b0 && w < 40 * bp) begin
        @(negedge clk);
        w++;
      end
      if (txd !== 1'b0) break;
      repeat (bp / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bp) @(negedge clk);
        b[i] = txd;
      end
      repeat (bp) @(negedge clk);
      if (txd === 1'b1) r.push_back(b);
    end
    repeat (18 * bp) @(negedge clk);
  endtask
endmodule // ledsfi_host

// File: tb/ledsfi_tb_top.sv
// Testbench of the frame interface: random and corner frames, refusals and fault sequences.
// Assumes ledsfi_core with the host model on the link and a register file answering here.
`timescale 1ns/1ps
module ledsfi_tb_top;
  logic clk, srst, en, rxd, txd, failsafe_n, channels_off, ro, rs, tw, ts, mask, sh, op;
  logic [3:0] dev_id;
  logic [7:0] fx;
  logic [15:0] reg_rdata;
  ledsfi_pkg::ledsfi_req_s reg_req;
  ledsfi_pkg::ledsfi_flags_s fault_flags;
  logic [26:0] wlog[$];
  logic [7:0] q[$], r[$], e[$];
  int mismatches, checks_done;
  ledsfi_core uut (.clk(clk), .srst(srst), .rxd(rxd), .en(en), .dev_id(dev_id), .ref_open_det(ro),
    .ref_short_det(rs), .temp_warn_det(tw), .temp_sd_det(ts), .overtemp_warning_failsafe_mask(mask),
    .any_channel_shorted(sh), .any_channel_unloaded(op), .reg_rdata(reg_rdata), .txd(txd),
    .failsafe_n(failsafe_n), .channels_off(channels_off), .reg_req(reg_req), .fault_flags(fault_flags));
  ledsfi_host host (.clk(clk), .txd(txd), .rxd(rxd));
  function automatic logic [7:0] rv(input logic [7:0] a, input logic hi);
    if (a == 8'h06) return hi ? fx : 8'h00;
    return hi ? ~a : a ^ 8'h5a;
  endfunction
  assign reg_rdata = {rv(reg_req.addr, 1'b1), rv(reg_req.addr, 1'b0)};
  always @(negedge clk) if (reg_req.wr === 1'b1 || reg_req.rd === 1'b1)
    wlog.push_back({reg_req.wr, reg_req.addr, reg_req.wdata, reg_req.wbe});
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmpq();
    cmp(r.size(), e.size());
    foreach (e[i]) if (i < r.size()) cmp(r[i], e[i]);
  endtask
  function automatic logic [7:0] stat();
    return {2'b10, sh, op, failsafe_n, 3'b000};
  endfunction
  task automatic wr(input logic [7:0] dv, input logic [7:0] ra, input int bp, input logic bad, acc, rep);
    int n;
    logic [7:0] d[$];
    n = 1 << dv[1:0];
    d = {};
    for (int i = 0; i < n; i++) d.push_back(8'($urandom));
    q = {dv, ra};
    foreach (d[i]) q.push_back(d[i]);
    wlog = {};
    host.frame(q, bp, 2, bad, r);
    e = {};
    if (rep) begin
      e.push_back(stat());
      e.push_back(host.crc8(e));
    end
    cmpq();
    cmp(wlog.size(), acc ? (n + 1) / 2 : 0);
    foreach (wlog[i]) cmp(wlog[i], {1'b1, ra + 8'(i), (n > 1) ? d[2 * i + 1] : wlog[i][17:10], d[2 * i],
      (n > 1) ? 2'b11 : 2'b01});
  endtask
  task automatic rd(input logic [7:0] dv, input logic [7:0] ra, input int bp, input logic rep);
    int n;
    n = 1 << dv[1:0];
    q = {dv, ra};
    wlog = {};
    host.frame(q, bp, 2 + n, 1'b0, r);
    e = {};
    if (rep) begin
      e.push_back(stat());
      for (int i = 0; i < n; i++) e.push_back(rv(ra + 8'(i / 2), i[0]));
      e.push_back(host.crc8(e));
    end
    cmpq();
    if (!rep) cmp(wlog.size(), 0);
  endtask
  initial begin
    {srst, en, ro, rs, tw, ts, mask, sh, op} = 9'b110000000;
    dev_id = 4'h0;
    fx = 8'h00;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(52));
    dev_id = 4'($urandom);
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (5) @(negedge clk);
    for (int c = 0; c < 8; c++) begin
      {sh, op} = 2'($urandom);
      if (c < 4) wr({dev_id, 1'b0, 3'(c)}, 8'h07 + 8'($urandom_range(0, 41)), 25, 1'b0, 1'b1, 1'b1);
      else rd({dev_id, 1'b0, 3'(c)}, 8'h07 + 8'($urandom_range(0, 41)), 25, 1'b1);
    end
    rd({dev_id, 4'h5}, 8'h33, 25, 1'b1);
    wr({dev_id, 4'h0}, 8'h34, 25, 1'b0, 1'b0, 1'b1);
    wr({~dev_id, 4'h1}, 8'h10, 25, 1'b0, 1'b0, 1'b0);
    wr({dev_id, 4'h1}, 8'h10, 25, 1'b1, 1'b0, 1'b0);
    wr({~dev_id, 4'h9}, 8'h11, 25, 1'b0, 1'b1, 1'b0);
    rd({dev_id, 4'hd}, 8'h11, 25, 1'b0);
    rd({dev_id, 4'h4}, 8'h20, 320, 1'b1);
    rs = 1'b1;
    repeat (5) @(negedge clk);
    rs = 1'b0;
    repeat (5) @(negedge clk);
    cmp({failsafe_n, channels_off}, 2'b01);
    fx = 8'h10;
    rd({dev_id, 4'h5}, 8'h06, 25, 1'b1);
    fx = 8'h00;
    rd({dev_id, 4'h5}, 8'h06, 25, 1'b1);
    ro = 1'b1;
    repeat (5) @(negedge clk);
    ro = 1'b0;
    en = 1'b0;
    repeat (6) @(negedge clk);
    cmp({failsafe_n, fault_flags}, 5'h00);
    en = 1'b1;
    repeat (6) @(negedge clk);
    cmp({failsafe_n, channels_off}, 2'b10);
    {mask, tw} = 2'b11;
    repeat (6) @(negedge clk);
    cmp(failsafe_n, 1'b1);
    mask = 1'b0;
    repeat (6) @(negedge clk);
    cmp(failsafe_n, 1'b0);
    tw = 1'b0;
    ts = 1'b1;
    repeat (6) @(negedge clk);
    cmp({failsafe_n, channels_off}, 2'b01);
    ts = 1'b0;
    repeat (6) @(negedge clk);
    cmp({failsafe_n, channels_off, fault_flags}, 6'h23);
    conclude();
  end
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule // ledsfi_tb_top
bind ledsfi_core ledsfi_properties chk (.clk(clk), .srst(srst), .en(en), .ref_open_det(ref_open_det),
  .ref_short_det(ref_short_det), .temp_warn_det(temp_warn_det), .temp_sd_det(temp_sd_det),
  .overtemp_warning_failsafe_mask(overtemp_warning_failsafe_mask), .failsafe_n(failsafe_n),
  .channels_off(channels_off), .reg_req(reg_req), .fault_flags(fault_flags));
